// *** src/acd_defs.svh ***
// Constants for the command decoder and result FIFO.
// Assumes inclusion by acd_top only.
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH
`define ACD_SETUP_RESET   8'h28
`define ACD_CTRL_RESET    8'h00
`define ACD_CKMODE_PIN    2'h0
`define ACD_CKMODE_SINGLE 2'h1
`define ACD_CKMODE_REG    2'h2
`define ACD_CKMODE_SCLK   2'h3
`define ACD_CMD_GPIO_CFG  8'h03
`define ACD_CMD_GPIO_WR   8'h02
`define ACD_CMD_GPIO_RD   8'h01
`define ACD_DAC_ONES      12'hfff
`define ACD_DAC_ZEROS     12'h000
`define ACD_RESULT_DEPTH  16
`define ACD_STRAP_WAIT    2'h3
`endif

// *** src/acd_pkg.sv ***
// Types shared by the command decoder.
// Assumes acd_defs.svh is on the include path.
package acd_pkg;
	typedef enum logic [2:0] {
		ACD_ST_CMD,
		ACD_ST_POL,
		ACD_ST_DAC,
		ACD_ST_GPIO,
		ACD_ST_SKIP
	} acd_state_e;
endpackage : acd_pkg

// *** src/acd_top.sv ***
// Serial command decoder with result FIFO for a multichannel converter.
// Assumes pins are asynchronous to clk; results arrive from the converter
// core as one-cycle strobes on clk.
// Function
// - Decode command bytes by leading-one position; zeros byte is no-op.
// - Conversion byte: channel bits 6-3, scan bits 2-1, temperature bit 0.
// - Setup byte: clock mode 5-4, reference 3-2, polarity register 1-0.
// - Averaging byte: enable bit 4, count 3-2, scan repeats 1-0.
// - Reset byte: reset request bit 2, slow bit 1, bandgap bit 0.
// - GPIO commands 03/02/01, read 01 is ignored; write takes one or two data bytes.
// - Without GPIO pins every GPIO command is ignored.
// - Power up shut down; registers zero except setup at 28h.
// - DAC input registers start all ones or zeros by wake-up pin.
// - Clock modes select pin, single, register or serial-clock start.
// - Serial-clock mode disables scanning and averaging.
// - End-of-conversion low when done except in mode 11 (held high), high on select/start fall.
// - Differential pairs are even/odd, even positive; channel count varies.
// - Shared start/reference/analog pin serves one function at a time.
// - Polarity register bits make pairs differential; unipolar negative is 0.
// - Unipolar straight binary, bipolar two's complement, single-ended unipolar.
// - FIFO holds sixteen ADC results plus one temperature slot.
// - Full FIFO overwrites oldest ADC result.
// - Results read as two bytes, four zeros then twelve bits.
// - Empty FIFO shifts out zeros.
// - Temperature read first; new temperature replaces unread one.
// - Temperature is two's complement, eight steps per degree.
// - Serial input sampled MSB first on falling serial clock edges.
// - Raising chip select resets the serial interface state.
`include "acd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Result FIFO
// ---------------------------------------------------------------
module acd_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("acd_fifo: DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    wr_ptr;
	logic [AW:0]      count;
	logic             do_wr;
	logic             do_rd;
	assign in_ready  = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end
endmodule : acd_fifo

// ---------------------------------------------------------------
// Decoder top
// ---------------------------------------------------------------
module acd_top
	import acd_pkg::*;
#(
	parameter int GPIO_BYTES = 2
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        din,
	output logic             dout,
	input  wire logic        conversion_start_n,
	input  wire logic        dac_wakeup_level_select,
	output logic             eoc_n,
	input  wire logic        conv_done,
	input  wire logic        result_valid,
	input  wire logic [11:0] result_data,
	input  wire logic        temp_valid,
	input  wire logic [11:0] temp_data,
	output logic [7:0]       conversion_control,
	output logic [7:0]       setup_control,
	output logic [7:0]       averaging_control,
	output logic [7:0]       reset_control,
	output logic [7:0]       unipolar_mode,
	output logic [7:0]       bipolar_mode,
	output logic             conversion_request,
	output logic             start_pin_enabled,
	output logic             scan_enabled,
	output logic             average_enabled,
	output logic [11:0]      dac_input,
	output logic             dac_write,
	output logic [7:0]       dac_select,
	output logic [15:0]      gpio_data,
	output logic             gpio_write,
	output logic             gpio_config
);
	initial begin
		if (GPIO_BYTES < 0 || GPIO_BYTES > 2)
			$error("acd_top: GPIO_BYTES must be 0, 1 or 2");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers and edges
	// ---------------------------------------------------------------
	logic [1:0] cs_s;
	logic [1:0] sck_s;
	logic [1:0] din_s;
	logic [1:0] cnv_s;
	logic       cs_d;
	logic       sck_d;
	logic       cnv_d;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_s  <= 2'h3;
			sck_s <= 2'h0;
			din_s <= 2'h0;
			cnv_s <= 2'h3;
			cs_d  <= 1'b1;
			sck_d <= 1'b0;
			cnv_d <= 1'b1;
		end else begin
			cs_s  <= {cs_s[0], cs_n};
			sck_s <= {sck_s[0], sclk};
			din_s <= {din_s[0], din};
			cnv_s <= {cnv_s[0], conversion_start_n};
			cs_d  <= cs_s[1];
			sck_d <= sck_s[1];
			cnv_d <= cnv_s[1];
		end
	end
	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	logic sck_rise;
	logic cnv_fall;
	logic active;
	assign cs_fall  = cs_d && !cs_s[1];
	assign cs_rise  = !cs_d && cs_s[1];
	assign sck_fall = sck_d && !sck_s[1];
	assign sck_rise = !sck_d && sck_s[1];
	assign cnv_fall = cnv_d && !cnv_s[1];
	assign active   = !cs_s[1];

	// ---------------------------------------------------------------
	// Byte assembly
	// ---------------------------------------------------------------
	logic [7:0] shreg;
	logic [2:0] bitcnt;
	logic       byte_done;
	logic [7:0] rx_byte;
	assign rx_byte = {shreg[6:0], din_s[1]};
	assign byte_done = active && sck_fall && bitcnt == 3'h7;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shreg  <= 8'h00;
			bitcnt <= 3'h0;
		end else if (!active) begin
			bitcnt <= 3'h0;
		end else if (sck_fall) begin
			shreg  <= rx_byte;
			bitcnt <= bitcnt + 3'h1;
		end
	end

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	acd_state_e state;
	logic       pol_bip;
	logic [1:0] left;
	logic [7:0] hold;
	logic       has_gpio;
	assign has_gpio = GPIO_BYTES != 0;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state              <= ACD_ST_CMD;
			pol_bip            <= 1'b0;
			left               <= 2'h0;
			hold               <= 8'h00;
			conversion_control <= `ACD_CTRL_RESET;
			setup_control      <= `ACD_SETUP_RESET;
			averaging_control  <= `ACD_CTRL_RESET;
			reset_control      <= `ACD_CTRL_RESET;
			unipolar_mode      <= `ACD_CTRL_RESET;
			bipolar_mode       <= `ACD_CTRL_RESET;
			conversion_request <= 1'b0;
			dac_select         <= 8'h00;
			dac_write          <= 1'b0;
			gpio_data          <= 16'h0000;
			gpio_write         <= 1'b0;
			gpio_config        <= 1'b0;
		end else begin
			conversion_request <= 1'b0;
			dac_write          <= 1'b0;
			gpio_write         <= 1'b0;
			gpio_config        <= 1'b0;
			if (!active) begin
				state <= ACD_ST_CMD;
			end else if (byte_done) begin
				case (state)
				ACD_ST_CMD: begin
					if (rx_byte[7]) begin
						conversion_control <= rx_byte;
						conversion_request <= 1'b1;
					end else if (rx_byte[6]) begin
						setup_control <= rx_byte;
						pol_bip <= rx_byte[0];
						if (rx_byte[1])
							state <= ACD_ST_POL;
					end else if (rx_byte[5]) begin
						averaging_control <= rx_byte;
					end else if (rx_byte[4]) begin
						left  <= 2'h2;
						state <= ACD_ST_DAC;
					end else if (rx_byte[3]) begin
						reset_control <= rx_byte;
					end else if (rx_byte == `ACD_CMD_GPIO_WR) begin
						if (has_gpio) begin
							left  <= 2'(GPIO_BYTES);
							state <= ACD_ST_GPIO;
						end
					end else if (rx_byte == `ACD_CMD_GPIO_CFG) begin
						if (has_gpio) begin
							left  <= 2'(GPIO_BYTES);
							state <= ACD_ST_SKIP;
						end
					end
				end
				ACD_ST_POL: begin
					if (pol_bip)
						bipolar_mode <= rx_byte;
					else
						unipolar_mode <= rx_byte;
					state <= ACD_ST_SKIP;
					left  <= 2'h0;
				end
				ACD_ST_DAC: begin
					hold <= rx_byte;
					left <= left - 2'h1;
					if (left == 2'h1) begin
						dac_select <= hold;
						dac_write  <= 1'b1;
						state      <= ACD_ST_SKIP;
					end
				end
				ACD_ST_GPIO: begin
					gpio_data <= {gpio_data[7:0], rx_byte};
					left      <= left - 2'h1;
					if (left == 2'h1) begin
						gpio_write <= 1'b1;
						state      <= ACD_ST_SKIP;
					end
				end
				ACD_ST_SKIP: begin
					if (left != 2'h0) begin
						left <= left - 2'h1;
						gpio_config <= left == 2'h1;
					end
				end
				default: state <= ACD_ST_CMD;
				endcase
			end
		end
	end

	// DAC input: strap passes two flops, then loads once after release
	logic [1:0] wake_s;
	logic [1:0] init_cnt;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_s    <= 2'h0;
			init_cnt  <= `ACD_STRAP_WAIT;
			dac_input <= `ACD_DAC_ZEROS;
		end else begin
			wake_s <= {wake_s[0], dac_wakeup_level_select};
			if (init_cnt != 2'h0)
				init_cnt <= init_cnt - 2'h1;
			if (init_cnt == 2'h1)
				dac_input <= wake_s[1] ? `ACD_DAC_ONES
					: `ACD_DAC_ZEROS;
			else if (state == ACD_ST_DAC && byte_done && left == 2'h1)
				dac_input <= {hold[3:0], rx_byte};
		end
	end

	// ---------------------------------------------------------------
	// Mode controls
	// ---------------------------------------------------------------
	logic [1:0] ck_mode;
	logic       sclk_mode;
	assign ck_mode   = setup_control[5:4];
	assign sclk_mode = ck_mode == `ACD_CKMODE_SCLK;
	// Shared pin is a start input only in modes 00 and 01
	assign start_pin_enabled = ck_mode == `ACD_CKMODE_PIN
		|| ck_mode == `ACD_CKMODE_SINGLE;
	assign scan_enabled    = !sclk_mode;
	assign average_enabled = !sclk_mode && averaging_control[4];
	// Pairing, coding and clamping are done in the analog core.

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			eoc_n <= 1'b1;
		else if (sclk_mode || cs_fall || (cnv_fall && start_pin_enabled))
			eoc_n <= 1'b1;
		else if (conv_done)
			eoc_n <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Results and readout
	// ---------------------------------------------------------------
	logic        f_in_ready;
	logic        f_out_valid;
	logic [11:0] f_out_data;
	logic        f_pop;
	logic        drop;
	logic [11:0] temp_slot;
	logic        temp_full;
	logic [15:0] txreg;
	logic        half;
	logic        boundary;
	logic        reload;
	logic        tx_temp;
	logic        tx_fifo;
	logic        pend_valid;
	logic [11:0] pend_data;
	// Full FIFO drops its head so the newest result still lands
	assign drop     = result_valid && !f_in_ready;
	// A word is used up only once all sixteen bits went out
	assign boundary = active && sck_fall && bitcnt == 3'h7 && half;
	assign f_pop    = drop || (boundary && tx_fifo && f_out_valid);

	acd_fifo #(
		.WIDTH (12),
		.DEPTH (`ACD_RESULT_DEPTH)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (pend_valid || (result_valid && !drop)),
		.in_ready  (f_in_ready),
		.in_data   (pend_valid ? pend_data : result_data),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data)
	);
	// Result that arrives while the FIFO is full waits one cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_valid <= 1'b0;
			pend_data  <= 12'h000;
		end else begin
			pend_valid <= drop;
			pend_data  <= result_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			temp_slot <= 12'h000;
			temp_full <= 1'b0;
		end else if (temp_valid) begin
			temp_slot <= temp_data;
			temp_full <= 1'b1;
		end else if (boundary && tx_temp) begin
			temp_full <= 1'b0;
		end
	end

	// Word boundary every sixteen bits; bitcnt covers a byte, so track half
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			half <= 1'b0;
		else if (!active)
			half <= 1'b0;
		else if (sck_fall && bitcnt == 3'h7)
			half <= !half;
	end

	// Peek on load, consume at the boundary: a cut frame loses nothing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txreg   <= 16'h0000;
			reload  <= 1'b0;
			tx_temp <= 1'b0;
			tx_fifo <= 1'b0;
		end else begin
			reload <= boundary;
			if (cs_fall || reload) begin
				tx_temp <= temp_full;
				tx_fifo <= !temp_full && f_out_valid;
				if (temp_full)
					txreg <= {4'h0, temp_slot};
				else if (f_out_valid)
					txreg <= {4'h0, f_out_data};
				else
					txreg <= 16'h0000;
			end else if (active && ((sclk_mode && sck_rise)
				|| (!sclk_mode && sck_fall))) begin
				txreg <= {txreg[14:0], 1'b0};
			end
		end
	end
	assign dout = txreg[15];
endmodule : acd_top
`default_nettype wire

// *** verification/acd_top_asserts.sv ***
// Port checker for the command decoder top.
// Assumes binding to acd_top; pins reach clk through synchronisers.
`timescale 1ns/1ps
`default_nettype none
module acd_top_asserts (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       cs_n,
	input wire logic       conversion_start_n,
	input wire logic       eoc_n,
	input wire logic       conv_done,
	input wire logic [7:0] conversion_control,
	input wire logic [7:0] setup_control,
	input wire logic [7:0] averaging_control,
	input wire logic       conversion_request,
	input wire logic       start_pin_enabled,
	input wire logic       scan_enabled,
	input wire logic       average_enabled,
	input wire logic       dac_write,
	input wire logic       gpio_write
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic ck11;
	assign ck11 = setup_control[5:4] == 2'h3;
	a_reset_value: assert property ($rose(resetn) |->
		setup_control == 8'h28 && averaging_control == 8'h00)
		else $error("power-up register value wrong");
	a_mode11_noscan: assert property (ck11 |->
		!scan_enabled && !average_enabled)
		else $error("scan or averaging on in mode 11");
	a_mode11_eoc: assert property (ck11 [*2] |-> eoc_n)
		else $error("eoc low in mode 11");
	a_done_eoc: assert property (conv_done && !ck11 |=> !eoc_n)
		else $error("eoc not low after done");
	// Six idle cycles clear the pin synchroniser delay
	a_eoc_holds: assert property ((!eoc_n && cs_n &&
		conversion_start_n) [*6] |=> !eoc_n)
		else $error("eoc released without select fall");
	a_write_starts: assert property ($changed(conversion_control) &&
		setup_control[5:4] == 2'h2 |-> conversion_request)
		else $error("no conversion request on write");
	a_quiet_idle: assert property (cs_n [*4] |-> !dac_write &&
		!gpio_write && $stable(setup_control))
		else $error("write while deselected");
	a_start_pin: assert property (start_pin_enabled ==
		!setup_control[5])
		else $error("start pin function wrong");
	a_avg_gate: assert property (average_enabled ==
		(averaging_control[4] && !ck11))
		else $error("averaging enable wrong");
	c_eoc: cover property (!eoc_n);
	c_conv: cover property (conversion_request);
	c_dac: cover property (dac_write);
endmodule : acd_top_asserts
`default_nettype wire

// *** verification/acd_spi_master.sv ***
// Serial master model for the decoder's pins.
// Assumes mode-0 framing; the link clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module acd_spi_master (
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// Din moves mid-low, clear of the sampled falling edge
	task automatic bits(input int n, input logic [23:0] tx,
		output logic [15:0] rx);
		rx = 16'h0;
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#80 din = tx[i];
			#80 sclk = 1'b1;
			rx = {rx[14:0], dout};
			#160 sclk = 1'b0;
		end
		#160 cs_n = 1'b1;
		din = ~din;
		#640;
	endtask : bits
endmodule : acd_spi_master
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the decoder and the result FIFO.
// Assumes acd_spi_master drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, resetn, cs_n, sclk, din, dout, eoc_n;
	logic        conversion_start_n, dac_wakeup_level_select;
	logic        conv_done, result_valid, temp_valid, conversion_request;
	logic        start_pin_enabled, scan_enabled, average_enabled;
	logic        dac_write, gpio_write, gpio_config;
	logic [7:0]  conversion_control, setup_control, averaging_control;
	logic [7:0]  reset_control, unipolar_mode, bipolar_mode, dac_select;
	logic [11:0] result_data, temp_data, dac_input;
	logic [15:0] gpio_data, rx;
	int          fail_count = 0;
	int          n_compared = 0;
	int          k;

	acd_top DUT (.*);
	acd_spi_master m (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// k: 0 result, 1 temperature, 2 conversion done
	task automatic strobe(input int k, input logic [11:0] d);
		@(negedge clk);
		{conv_done, temp_valid, result_valid} = 3'(1 << k);
		result_data = d;
		temp_data = d;
		@(negedge clk);
		{conv_done, temp_valid, result_valid} = 3'h0;
	endtask : strobe
	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		#2ms;
		fail_count++;
		wrap_up();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{resetn, conv_done, temp_valid, result_valid} = 4'h0;
		{conversion_start_n, dac_wakeup_level_select} = 2'h3;
		{result_data, temp_data} = 24'h0;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		chk(32'(setup_control), 32'h28);
		chk(32'({conversion_control, averaging_control}), 32'h0);
		chk(32'({reset_control, unipolar_mode, bipolar_mode, eoc_n}), 32'h1);
		chk(32'(dac_input), 32'hfff);
		m.bits(8, 24'hb5, rx);
		chk(32'(conversion_control[6:0]), 32'h35);
		strobe(2, 12'h0);
		repeat (8) @(negedge clk);
		chk(32'(eoc_n), 32'h0);
		m.bits(16, 24'h008f, rx);
		chk(32'({eoc_n, conversion_control[6:0]}), 32'h8f);
		m.bits(5, 24'h13, rx);
		m.bits(8, 24'h8a, rx);
		chk(32'(conversion_control[6:0]), 32'h0a);
		m.bits(8, 24'h3f, rx);
		chk(32'({average_enabled, averaging_control[4:0]}), 32'h3f);
		m.bits(8, 24'h0d, rx);
		chk(32'(reset_control[2:0]), 32'h5);
		m.bits(8, 24'h7c, rx);
		chk(32'(setup_control[5:0]), 32'h3c);
		chk(32'({scan_enabled, average_enabled}), 32'h0);
		strobe(2, 12'h0);
		repeat (4) @(negedge clk);
		chk(32'(eoc_n), 32'h1);
		m.bits(8, 24'h40, rx);
		chk(32'(start_pin_enabled), 32'h1);
		strobe(2, 12'h0);
		repeat (2) @(negedge clk);
		chk(32'(eoc_n), 32'h0);
		conversion_start_n = 1'b0;
		repeat (4) @(negedge clk);
		conversion_start_n = 1'b1;
		chk(32'(eoc_n), 32'h1);
		m.bits(16, 24'h625a, rx);
		chk(32'(unipolar_mode), 32'h5a);
		m.bits(16, 24'h63a5, rx);
		chk(32'({bipolar_mode, setup_control[5:0]}), 32'h2963);
		m.bits(24, 24'h1f37bc, rx);
		chk(32'({dac_select, dac_input}), 32'h377bc);
		m.bits(24, 24'h021234, rx);
		chk(32'(gpio_data), 32'h1234);
		m.bits(16, 24'h0, rx);
		chk(32'(rx), 32'h0);
		strobe(1, 12'h0f8);
		strobe(1, 12'hf08);
		for (k = 0; k < 17; k++)
			strobe(0, 12'(12'h100 + k));
		// Oldest result lost to overflow, newest kept, temperature first
		for (k = 0; k < 17; k++) begin
			m.bits(16, 24'h0, rx);
			chk(32'(rx), k ? 32'h100 + k : 32'hf08);
		end
		m.bits(16, 24'h0, rx);
		chk(32'(rx), 32'h0);
		// Second word of a long frame is not used up by a cut frame
		strobe(0, 12'h2aa);
		strobe(0, 12'h355);
		m.bits(24, 24'h0, rx);
		chk(32'(rx), 32'haa03);
		m.bits(16, 24'h0, rx);
		chk(32'(rx), 32'h355);
		wrap_up();
	end
endmodule : tb_top

bind acd_top acd_top_asserts u_chk (
	.clk(clk), .resetn(resetn), .cs_n(cs_n),
	.conversion_start_n(conversion_start_n), .eoc_n(eoc_n),
	.conv_done(conv_done), .conversion_control(conversion_control),
	.setup_control(setup_control), .averaging_control(averaging_control),
	.conversion_request(conversion_request),
	.start_pin_enabled(start_pin_enabled), .scan_enabled(scan_enabled),
	.average_enabled(average_enabled), .dac_write(dac_write),
	.gpio_write(gpio_write));
`default_nettype wire
